// ---- inc/dod_pkg.sv ----
// Opcode patterns, field positions, cycle counts and types of the partial instruction decoder
package dod_pkg;
   // ==========================================
   // Word and field layout
   localparam int          WORD_W     = 16;
   localparam int          ADDR_W     = 8;
   localparam int          SHIFT_W    = 4;
   localparam int          CNT_W      = 3;
   localparam int          SET_W      = 7;
   localparam int          SEL_HI_BIT = 11;
   // ==========================================
   // Whole-word opcodes
   localparam logic [15:0] WORD_POP_ACC   = 16'hbe32;
   localparam logic [15:0] WORD_PUSH_ACC  = 16'hbe3c;
   localparam logic [15:0] WORD_EXIT      = 16'hef00;
   localparam logic [15:0] WORD_PMINUS    = 16'hbe05;
   localparam logic [15:0] WORD_XOR_LK16  = 16'hbe83;
   // ==========================================
   // Upper-byte opcodes
   localparam logic [7:0]  UB_POP_MEM     = 8'h8a;
   localparam logic [7:0]  UB_PUSH_MEM    = 8'h76;
   localparam logic [7:0]  UB_REP_IMM     = 8'hbb;
   localparam logic [7:0]  UB_REP_MEM     = 8'h0b;
   localparam logic [7:0]  UB_AUX_DEC     = 8'h7c;
   localparam logic [7:0]  UB_PSHIFT_SEL  = 8'hbf;
   localparam logic [7:0]  UB_SQ_MINUS    = 8'h53;
   localparam logic [7:0]  UB_SQ_ACC      = 8'h52;
   localparam logic [7:0]  UB_STAT0       = 8'h8e;
   localparam logic [7:0]  UB_STAT1       = 8'h8f;
   localparam logic [7:0]  UB_LK_STORE    = 8'hae;
   localparam logic [7:0]  UB_SUB_HIGH    = 8'h65;
   localparam logic [7:0]  UB_SUB_SHORT   = 8'hba;
   localparam logic [7:0]  UB_SUB_BORROW  = 8'h64;
   localparam logic [7:0]  UB_SUB_NOSX    = 8'h66;
   localparam logic [7:0]  UB_COND_MINUS  = 8'h0a;
   localparam logic [7:0]  UB_SUB_VSHIFT  = 8'h67;
   localparam logic [7:0]  UB_LOAD_HROUND = 8'h68;
   // ==========================================
   // Prefix opcodes
   localparam logic [5:0]  PFX_COND_EXIT  = 6'h3b;
   localparam logic [3:0]  NIB_ACC_STORE  = 4'h9;
   localparam logic [3:0]  NIB_SUB_SHF    = 4'h3;
   localparam logic [11:0] PFX_SET_BIT    = 12'hbe4;
   localparam logic [11:0] PFX_SUB_LK     = 12'hbfa;
   localparam logic [11:0] PFX_XOR_LK     = 12'hbfd;
   // ==========================================
   // Status-bit selectors and set-vector positions
   localparam logic [3:0]  SEL_CARRY = 4'hf;
   localparam logic [3:0]  SEL_BLOCK = 4'h5;
   localparam logic [3:0]  SEL_INTD  = 4'h1;
   localparam logic [3:0]  SEL_OVM   = 4'h3;
   localparam logic [3:0]  SEL_TC    = 4'hb;
   localparam logic [3:0]  SEL_EXT_FLAG = 4'hd;
   localparam logic [3:0]  SEL_SXM   = 4'h7;
   localparam int          BIT_CARRY = 0;
   localparam int          BIT_BLOCK = 1;
   localparam int          BIT_INTD  = 2;
   localparam int          BIT_OVM   = 3;
   localparam int          BIT_TC    = 4;
   localparam int          BIT_EXT_FLAG = 5;
   localparam int          BIT_SXM   = 6;
   // ==========================================
   // Condition test field of the conditional exit
   localparam logic [1:0]  TP_TC_SET = 2'b01;
   localparam logic [1:0]  TP_TC_CLR = 2'b10;
   // ==========================================
   // Cycle counts beyond the fetch cycles
   localparam logic [2:0]  XTRA_NONE     = 3'h0;
   localparam logic [2:0]  XTRA_EXIT     = 3'h3;
   localparam logic [2:0]  XTRA_EXIT_NOT = 3'h1;
   // ==========================================
   // Decoded operations
   typedef enum logic [5:0] {
      op_none,
      op_pop_acc,
      op_stack_pop_to_memory,
      op_memory_push_to_stack,
      op_push_acc,
      op_subroutine_exit,
      op_conditional_subroutine_exit,
      op_repeat_imm,
      op_repeat_mem,
      op_acc_high_store_shifted,
      op_acc_low_store_shifted,
      op_aux_pointer_decrement_imm,
      op_status_bit_setter,
      op_product_minus_from_acc,
      op_product_shift_select,
      op_square_accumulate,
      op_square_minus_product,
      op_store_status_word_zero,
      op_store_status_word_one,
      op_long_constant_store,
      op_sub_long_shifted,
      op_sub_shifted,
      op_sub_high,
      op_sub_short_imm,
      op_acc_minus_with_borrow,
      op_acc_minus_no_sign_ext,
      op_conditional_minus,
      op_acc_minus_variable_shift,
      op_xor_long16,
      op_xor_long_shifted,
      op_load_high_rounded,
      op_foreign
   } dod_op_t;
   typedef enum logic {st_first, st_second} dod_state_t;
endpackage

// ---- inc/dod_timer_if.sv ----
// Carrier between the decoder and its execution-cycle timer
`timescale 1ns/1ps
interface dod_timer_if;
   logic                      start;
   logic [dod_pkg::CNT_W-1:0] extra;
   logic                      busy;
   modport ctl (output start, output extra, input busy);
   modport tmr (input start, input extra, output busy);
endinterface

// ---- src/dod_exec_timer.sv ----
// Counts the cycles an issued operation still occupies the decoder
`timescale 1ns/1ps
module dod_exec_timer (
   input  wire logic clk,   // Core clock
   input  wire logic rst_b, // Synchronous reset, active low
   dod_timer_if.tmr  tif    // Start and busy carrier
);
   logic [dod_pkg::CNT_W-1:0] count;

   // ==========================================
   // Down counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count <= dod_pkg::XTRA_NONE;
      end else if (tif.start) begin
         count <= tif.extra;
      end else if (count != dod_pkg::XTRA_NONE) begin
         count <= count - 3'h1;
      end
   end

   assign tif.busy = (count != dod_pkg::XTRA_NONE);
endmodule

// ---- src/dod_decoder.sv ----
// Partial instruction decoder of the fixed-point signal processor core
// Operation
// - Word be32 pops stack top into low accumulator, one word one cycle
// - Upper byte 8a pops stack top into data memory, low byte addresses
// - Upper byte 76 pushes addressed data-memory value onto the stack
// - Word be3c pushes low accumulator onto stack, one word one cycle
// - Word ef00 exits in four cycles; conditional exit four taken, two not
// - Repeat next: bb with 8-bit count, or 0b with memory count
// - Nibble 9 stores accumulator; bit 11 picks high half, bits 10:8 shift
// - Upper byte 7c subtracts short immediate from current auxiliary register
// - Words be4x with low nibble f, 5, 1, 3, b, d or 7 set the one status bit it selects
// - Word be05 subtracts product from accumulator in one cycle
// - Upper byte bf sets product shift mode from the low byte, one cycle
// - Upper byte 53 squares and subtracts product, 52 squares and accumulates
// - Upper bytes 8e and 8f store status words zero and one to memory
// - Upper byte ae then a 16-bit constant stores it, two cycles
// - Prefix bfa with shift then a constant subtracts it shifted, two cycles
// - Nibble 3 subtracts shifted memory; upper byte 65 subtracts from high half
// - Upper byte ba subtracts 8-bit short immediate from accumulator
// - Upper byte 64 subtracts memory operand and inverted carry
// - Upper byte 66 subtracts without sign extension; 0a is conditional subtract
// - Upper byte 67 subtracts memory shifted by the multiplicand register
// - be83 or bfd with shift then a constant exclusive-ORs it, two cycles
// - Upper byte 68 clears low half and loads high half rounded
`timescale 1ns/1ps
module dod_decoder (
   input  wire logic                          clk,         // Core clock
   input  wire logic                          rst_b,       // Synchronous reset, active low
   input  wire logic                          instr_valid, // Program memory word present
   input  wire logic [dod_pkg::WORD_W-1:0]    instr_word,  // Program memory word
   output logic                               instr_ready, // Decoder takes a word
   input  wire logic                          flag_z,      // Accumulator zero
   input  wire logic                          flag_lt,     // Accumulator negative
   input  wire logic                          flag_ov,     // Overflow flag
   input  wire logic                          flag_c,      // Carry flag
   input  wire logic                          flag_tc,     // Test/control flag
   output logic                               op_valid,    // Operation issued, one cycle
   output dod_pkg::dod_op_t                   op_kind,     // Issued operation
   output logic [dod_pkg::ADDR_W-1:0]         addr_field,  // Addressing field
   output logic [dod_pkg::WORD_W-1:0]         imm_word,    // Immediate or constant
   output logic [dod_pkg::SHIFT_W-1:0]        shift_amt,   // Shift count
   output logic [dod_pkg::SET_W-1:0]          status_set,  // One-hot status bit to set
   output logic                               exit_taken   // Exit taken, unconditional or condition met
);
   dod_timer_if tif ();

   dod_pkg::dod_state_t               state;
   dod_pkg::dod_op_t                  pend_op;
   logic [dod_pkg::WORD_W-1:0]        pend_word;
   dod_pkg::dod_op_t                  dec_op;
   logic                              first_take;
   logic                              second_take;
   logic                              cond_ok;

   // ==========================================
   // Decode functions
   function automatic dod_pkg::dod_op_t decode_op(input logic [15:0] w);
      logic [7:0] ub;
      ub = w[15:8];
      decode_op = dod_pkg::op_foreign;
      if (w == dod_pkg::WORD_POP_ACC) begin
         decode_op = dod_pkg::op_pop_acc;
      end else if (w == dod_pkg::WORD_PUSH_ACC) begin
         decode_op = dod_pkg::op_push_acc;
      end else if (w == dod_pkg::WORD_EXIT) begin
         decode_op = dod_pkg::op_subroutine_exit;
      end else if (w[15:10] == dod_pkg::PFX_COND_EXIT) begin
         decode_op = dod_pkg::op_conditional_subroutine_exit;
      end else if (w == dod_pkg::WORD_PMINUS) begin
         decode_op = dod_pkg::op_product_minus_from_acc;
      end else if (w == dod_pkg::WORD_XOR_LK16) begin
         decode_op = dod_pkg::op_xor_long16;
      end else if (w[15:4] == dod_pkg::PFX_SET_BIT) begin
         if (set_vec(w[3:0]) != '0) begin
            decode_op = dod_pkg::op_status_bit_setter;
         end
      end else if (w[15:4] == dod_pkg::PFX_SUB_LK) begin
         decode_op = dod_pkg::op_sub_long_shifted;
      end else if (w[15:4] == dod_pkg::PFX_XOR_LK) begin
         decode_op = dod_pkg::op_xor_long_shifted;
      end else if (ub == dod_pkg::UB_PSHIFT_SEL) begin
         decode_op = dod_pkg::op_product_shift_select;
      end else if (ub == dod_pkg::UB_POP_MEM) begin
         decode_op = dod_pkg::op_stack_pop_to_memory;
      end else if (ub == dod_pkg::UB_PUSH_MEM) begin
         decode_op = dod_pkg::op_memory_push_to_stack;
      end else if (ub == dod_pkg::UB_REP_IMM) begin
         decode_op = dod_pkg::op_repeat_imm;
      end else if (ub == dod_pkg::UB_REP_MEM) begin
         decode_op = dod_pkg::op_repeat_mem;
      end else if (w[15:12] == dod_pkg::NIB_ACC_STORE) begin
         decode_op = w[dod_pkg::SEL_HI_BIT] ? dod_pkg::op_acc_high_store_shifted
                                             : dod_pkg::op_acc_low_store_shifted;
      end else if (ub == dod_pkg::UB_AUX_DEC) begin
         decode_op = dod_pkg::op_aux_pointer_decrement_imm;
      end else if (ub == dod_pkg::UB_SQ_MINUS) begin
         decode_op = dod_pkg::op_square_minus_product;
      end else if (ub == dod_pkg::UB_SQ_ACC) begin
         decode_op = dod_pkg::op_square_accumulate;
      end else if (ub == dod_pkg::UB_STAT0) begin
         decode_op = dod_pkg::op_store_status_word_zero;
      end else if (ub == dod_pkg::UB_STAT1) begin
         decode_op = dod_pkg::op_store_status_word_one;
      end else if (ub == dod_pkg::UB_LK_STORE) begin
         decode_op = dod_pkg::op_long_constant_store;
      end else if (w[15:12] == dod_pkg::NIB_SUB_SHF) begin
         decode_op = dod_pkg::op_sub_shifted;
      end else if (ub == dod_pkg::UB_SUB_HIGH) begin
         decode_op = dod_pkg::op_sub_high;
      end else if (ub == dod_pkg::UB_SUB_SHORT) begin
         decode_op = dod_pkg::op_sub_short_imm;
      end else if (ub == dod_pkg::UB_SUB_BORROW) begin
         decode_op = dod_pkg::op_acc_minus_with_borrow;
      end else if (ub == dod_pkg::UB_SUB_NOSX) begin
         decode_op = dod_pkg::op_acc_minus_no_sign_ext;
      end else if (ub == dod_pkg::UB_COND_MINUS) begin
         decode_op = dod_pkg::op_conditional_minus;
      end else if (ub == dod_pkg::UB_SUB_VSHIFT) begin
         decode_op = dod_pkg::op_acc_minus_variable_shift;
      end else if (ub == dod_pkg::UB_LOAD_HROUND) begin
         decode_op = dod_pkg::op_load_high_rounded;
      end
   endfunction

   function automatic logic [6:0] set_vec(input logic [3:0] sel);
      set_vec = '0;
      case (sel)
         dod_pkg::SEL_CARRY: set_vec[dod_pkg::BIT_CARRY] = 1'b1;
         dod_pkg::SEL_BLOCK: set_vec[dod_pkg::BIT_BLOCK] = 1'b1;
         dod_pkg::SEL_INTD:  set_vec[dod_pkg::BIT_INTD]  = 1'b1;
         dod_pkg::SEL_OVM:   set_vec[dod_pkg::BIT_OVM]   = 1'b1;
         dod_pkg::SEL_TC:    set_vec[dod_pkg::BIT_TC]    = 1'b1;
         dod_pkg::SEL_EXT_FLAG: set_vec[dod_pkg::BIT_EXT_FLAG] = 1'b1;
         dod_pkg::SEL_SXM:   set_vec[dod_pkg::BIT_SXM]   = 1'b1;
         default:            set_vec = '0;
      endcase
   endfunction

   function automatic logic two_word(input dod_pkg::dod_op_t op);
      two_word = (op == dod_pkg::op_long_constant_store) ||
                 (op == dod_pkg::op_sub_long_shifted) ||
                 (op == dod_pkg::op_xor_long16) ||
                 (op == dod_pkg::op_xor_long_shifted);
   endfunction

   // Cycles held after the issue cycle
   function automatic logic [2:0] extra_cycles(input dod_pkg::dod_op_t op, input logic tk);
      extra_cycles = dod_pkg::XTRA_NONE;
      if (op == dod_pkg::op_subroutine_exit) begin
         extra_cycles = dod_pkg::XTRA_EXIT;
      end else if (op == dod_pkg::op_conditional_subroutine_exit) begin
         extra_cycles = tk ? dod_pkg::XTRA_EXIT : dod_pkg::XTRA_EXIT_NOT;
      end
   endfunction

   // ==========================================
   // Condition test: high nibble masks, low nibble gives required flag values
   always_comb begin
      logic [3:0] fl;
      fl = {flag_z, flag_lt, flag_ov, flag_c};
      cond_ok = &(~instr_word[7:4] | ~(fl ^ instr_word[3:0]));
      if (instr_word[9:8] == dod_pkg::TP_TC_SET) begin
         cond_ok = cond_ok & flag_tc;
      end else if (instr_word[9:8] == dod_pkg::TP_TC_CLR) begin
         cond_ok = cond_ok & ~flag_tc;
      end
   end

   assign dec_op      = decode_op(instr_word);
   assign instr_ready = !tif.busy;
   assign first_take  = instr_valid && instr_ready && (state == dod_pkg::st_first);
   assign second_take = instr_valid && instr_ready && (state == dod_pkg::st_second);

   // ==========================================
   // Word sequencing
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state     <= dod_pkg::st_first;
         pend_op   <= dod_pkg::op_none;
         pend_word <= '0;
      end else if (first_take && two_word(dec_op)) begin
         state     <= dod_pkg::st_second;
         pend_op   <= dec_op;
         pend_word <= instr_word;
      end else if (second_take) begin
         state     <= dod_pkg::st_first;
      end
   end

   // ==========================================
   // Timer start
   always_comb begin
      tif.start = first_take && !two_word(dec_op);
      tif.extra = extra_cycles(dec_op, cond_ok);
   end

   dod_exec_timer u_timer (
      .clk   (clk),
      .rst_b (rst_b),
      .tif   (tif)
   );

   // ==========================================
   // Issued operation outputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         op_valid   <= 1'b0;
         op_kind    <= dod_pkg::op_none;
         addr_field <= '0;
         imm_word   <= '0;
         shift_amt  <= '0;
         status_set <= '0;
         exit_taken <= 1'b0;
      end else if (first_take && !two_word(dec_op)) begin
         op_valid   <= 1'b1;
         op_kind    <= dec_op;
         addr_field <= instr_word[7:0];
         imm_word   <= {8'h00, instr_word[7:0]};
         shift_amt  <= (instr_word[15:12] == dod_pkg::NIB_ACC_STORE) ?
                       {1'b0, instr_word[10:8]} : instr_word[11:8];
         status_set <= (dec_op == dod_pkg::op_status_bit_setter) ?
                       set_vec(instr_word[3:0]) : '0;
         exit_taken <= (dec_op == dod_pkg::op_subroutine_exit) ||
                       ((dec_op == dod_pkg::op_conditional_subroutine_exit) && cond_ok);
      end else if (second_take) begin
         op_valid   <= 1'b1;
         op_kind    <= pend_op;
         addr_field <= pend_word[7:0];
         imm_word   <= instr_word;
         shift_amt  <= pend_word[3:0];
         status_set <= '0;
         exit_taken <= 1'b0;
      end else begin
         op_valid   <= 1'b0;
      end
   end

   // ==========================================
   // Checks
   sequence s_first(logic [15:0] w);
      first_take && (instr_word == w);
   endsequence

   sequence s_hold3;
      !instr_ready [*3] ##1 instr_ready;
   endsequence

   property p_pop_acc;
      @(posedge clk) disable iff (!rst_b)
      s_first(dod_pkg::WORD_POP_ACC) |=> op_valid && instr_ready &&
         (op_kind == dod_pkg::op_pop_acc);
   endproperty
   a_pop_acc: assert property (p_pop_acc) else $error("pop to accumulator misdecoded");

   property p_push_acc;
      @(posedge clk) disable iff (!rst_b)
      s_first(dod_pkg::WORD_PUSH_ACC) |=> op_valid && instr_ready &&
         (op_kind == dod_pkg::op_push_acc);
   endproperty
   a_push_acc: assert property (p_push_acc) else $error("push accumulator misdecoded");

   property p_exit_four;
      @(posedge clk) disable iff (!rst_b)
      s_first(dod_pkg::WORD_EXIT) |=> op_valid ##0 s_hold3;
   endproperty
   a_exit_four: assert property (p_exit_four) else $error("exit not four cycles");

   property p_cond_exit_not;
      @(posedge clk) disable iff (!rst_b)
      (first_take && (dec_op == dod_pkg::op_conditional_subroutine_exit) && !cond_ok)
         |=> !instr_ready && !exit_taken ##1 instr_ready;
   endproperty
   a_cond_exit_not: assert property (p_cond_exit_not) else $error("untaken exit not two cycles");

   property p_acc_store;
      @(posedge clk) disable iff (!rst_b)
      (first_take && (instr_word[15:12] == dod_pkg::NIB_ACC_STORE)) |=>
         (shift_amt == {1'b0, $past(instr_word[10:8])}) &&
         ((op_kind == dod_pkg::op_acc_high_store_shifted) == $past(instr_word[11]));
   endproperty
   a_acc_store: assert property (p_acc_store) else $error("store half or shift wrong");

   property p_set_carry;
      @(posedge clk) disable iff (!rst_b)
      s_first({dod_pkg::PFX_SET_BIT, dod_pkg::SEL_CARRY}) |=>
         (status_set == 7'h01) && (op_kind == dod_pkg::op_status_bit_setter);
   endproperty
   a_set_carry: assert property (p_set_carry) else $error("carry set misdecoded");

   property p_repeat_count;
      @(posedge clk) disable iff (!rst_b)
      (first_take && (instr_word[15:8] == dod_pkg::UB_REP_IMM)) |=>
         (imm_word == {8'h00, $past(instr_word[7:0])}) && (op_kind == dod_pkg::op_repeat_imm);
   endproperty
   a_repeat_count: assert property (p_repeat_count) else $error("repeat count wrong");

   property p_long_store;
      @(posedge clk) disable iff (!rst_b)
      (first_take && (instr_word[15:8] == dod_pkg::UB_LK_STORE)) |=> !op_valid &&
         (state == dod_pkg::st_second) && (pend_op == dod_pkg::op_long_constant_store);
   endproperty
   a_long_store: assert property (p_long_store) else $error("long store sequence wrong");

   property p_long_second;
      @(posedge clk) disable iff (!rst_b)
      (second_take && (pend_op == dod_pkg::op_long_constant_store)) |=> op_valid &&
         (op_kind == dod_pkg::op_long_constant_store) && (imm_word == $past(instr_word));
   endproperty
   a_long_second: assert property (p_long_second) else $error("long store constant lost");

   property p_addr_field;
      @(posedge clk) disable iff (!rst_b)
      (first_take && !two_word(dec_op)) |=> addr_field == $past(instr_word[7:0]);
   endproperty
   a_addr_field: assert property (p_addr_field) else $error("address field not passed");
endmodule

// ---- tb/dod_prog_mem.sv ----
// Program memory model that offers instruction words to the decoder
`timescale 1ns/1ps
module dod_prog_mem (
   input  wire logic        clk,         // Core clock
   input  wire logic        instr_ready, // Decoder takes a word
   output logic             instr_valid, // Word present
   output logic [15:0]      instr_word   // Instruction word
);
   initial begin
      instr_valid = 1'b0;
      instr_word  = 16'h0000;
   end
   // Holds the word until the edge that takes it
   task automatic offer(input logic [15:0] w);
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word  = w;
      while (instr_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
   endtask
   // A released bus shows the inverse of the last word
   task automatic idle();
      @(negedge clk);
      instr_valid = 1'b0;
      instr_word  = ~instr_word;
   endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the partial instruction decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
   typedef struct {logic [15:0] w; dod_pkg::dod_op_t op; logic [6:0] st;} dod_row_t;
   logic clk = 1'b0;
   logic rst_b, fz, fl, fo, fc, ft, iv, ir, ov, xt;
   logic [15:0] iw, imm;
   logic [7:0]  af;
   logic [3:0]  sh;
   logic [6:0]  ss;
   dod_pkg::dod_op_t ok;
   int failures = 0;
   int n_compared = 0;
   time t0;
   dod_row_t rows [31] = '{
      '{16'hbe32, dod_pkg::op_pop_acc, 7'h00}, '{16'h8a12, dod_pkg::op_stack_pop_to_memory, 7'h00},
      '{16'h7634, dod_pkg::op_memory_push_to_stack, 7'h00}, '{16'hbe3c, dod_pkg::op_push_acc, 7'h00},
      '{16'hbb05, dod_pkg::op_repeat_imm, 7'h00}, '{16'h0b40, dod_pkg::op_repeat_mem, 7'h00},
      '{16'h9d21, dod_pkg::op_acc_high_store_shifted, 7'h00},
      '{16'h9522, dod_pkg::op_acc_low_store_shifted, 7'h00},
      '{16'h7c07, dod_pkg::op_aux_pointer_decrement_imm, 7'h00},
      '{16'hbe4f, dod_pkg::op_status_bit_setter, 7'h01},
      '{16'hbe45, dod_pkg::op_status_bit_setter, 7'h02}, '{16'hbe41, dod_pkg::op_status_bit_setter, 7'h04},
      '{16'hbe43, dod_pkg::op_status_bit_setter, 7'h08}, '{16'hbe4b, dod_pkg::op_status_bit_setter, 7'h10},
      '{16'hbe4d, dod_pkg::op_status_bit_setter, 7'h20}, '{16'hbe47, dod_pkg::op_status_bit_setter, 7'h40},
      '{16'hbe05, dod_pkg::op_product_minus_from_acc, 7'h00},
      '{16'hbf33, dod_pkg::op_product_shift_select, 7'h00},
      '{16'h5311, dod_pkg::op_square_minus_product, 7'h00}, '{16'h5212, dod_pkg::op_square_accumulate, 7'h00},
      '{16'h8e13, dod_pkg::op_store_status_word_zero, 7'h00},
      '{16'h8f14, dod_pkg::op_store_status_word_one, 7'h00}, '{16'h3a15, dod_pkg::op_sub_shifted, 7'h00},
      '{16'h6516, dod_pkg::op_sub_high, 7'h00}, '{16'hba17, dod_pkg::op_sub_short_imm, 7'h00},
      '{16'h6418, dod_pkg::op_acc_minus_with_borrow, 7'h00},
      '{16'h6619, dod_pkg::op_acc_minus_no_sign_ext, 7'h00}, '{16'h0a1a, dod_pkg::op_conditional_minus, 7'h00},
      '{16'h671b, dod_pkg::op_acc_minus_variable_shift, 7'h00},
      '{16'h681c, dod_pkg::op_load_high_rounded, 7'h00}, '{16'hbe42, dod_pkg::op_foreign, 7'h00}};
   logic [15:0] two [4][2] = '{'{16'hae21, 16'h1234}, '{16'hbfa5, 16'habcd},
                               '{16'hbfd3, 16'h55aa}, '{16'hbe83, 16'h0f0f}};
   dod_pkg::dod_op_t two_op [4] = '{dod_pkg::op_long_constant_store, dod_pkg::op_sub_long_shifted,
                                    dod_pkg::op_xor_long_shifted, dod_pkg::op_xor_long16};
   always #2.5 clk = ~clk;
   dod_prog_mem pm (.clk(clk), .instr_ready(ir), .instr_valid(iv), .instr_word(iw));
   dod_decoder dut (.clk(clk), .rst_b(rst_b), .instr_valid(iv), .instr_word(iw), .instr_ready(ir),
      .flag_z(fz), .flag_lt(fl), .flag_ov(fo), .flag_c(fc), .flag_tc(ft), .op_valid(ov),
      .op_kind(ok), .addr_field(af), .imm_word(imm), .shift_amt(sh), .status_set(ss),
      .exit_taken(xt));
   task automatic print_verdict();
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Issues one word, then counts the cycles the decoder refuses further words
   task automatic run1(input logic [15:0] w, input int xtra);
      int n;
      n = 0;
      pm.offer(w);
      pm.idle();
      `CHK("op_valid", 1'b1, ov)
      while (ir !== 1'b1 && n < 8) begin
         n++;
         @(negedge clk);
      end
      `CHK("busy cycles", xtra, n)
   endtask
   initial begin
      #(5 * 3000);
      failures++;
      print_verdict();
   end
   initial begin
      {rst_b, fz, fl, fo, fc, ft} = 6'h00;
      repeat (6) @(negedge clk);
      `CHK("reset idle", 40'h80_0000_0000, {ir, ov, xt, ok, af, imm, ss})
      rst_b = 1'b1;
      foreach (rows[i]) begin
         run1(rows[i].w, 0);
         `CHK("op_kind", rows[i].op, ok)
         `CHK("addr_field", rows[i].w[7:0], af)
         `CHK("imm_word", {8'h00, rows[i].w[7:0]}, imm)
         `CHK("shift_amt", rows[i].w[15:12] == 4'h9 ? {1'b0, rows[i].w[10:8]} : rows[i].w[11:8], sh)
         `CHK("status_set", rows[i].st, ss)
      end
      foreach (two[i]) begin
         pm.offer(two[i][0]);
         #1 `CHK("first word quiet", 1'b0, ov)
         run1(two[i][1], 0);
         `CHK("two-word op", {two_op[i], two[i][0][7:0], two[i][1], two[i][0][3:0]}, {ok, af, imm, sh})
      end
      run1(16'hef00, 3);
      `CHK("exit", {dod_pkg::op_subroutine_exit, 1'b1}, {ok, xt})
      fc = 1'b1;
      run1(16'hec11, 3);
      `CHK("cond exit taken", {dod_pkg::op_conditional_subroutine_exit, 1'b1}, {ok, xt})
      fc = 1'b0;
      run1(16'hec11, 1);
      `CHK("cond exit skipped", 1'b0, xt)
      run1(16'hed00, 1);
      `CHK("tc exit skipped", 1'b0, xt)
      {fz, fl, fo, ft} = 4'hf;
      run1(16'hedee, 3);
      `CHK("all flags exit", 1'b1, xt)
      fo = 1'b0;
      run1(16'hedee, 1);
      `CHK("overflow exit skipped", 1'b0, xt)
      {fz, fl, fo, ft} = 4'h0;
      pm.offer(16'hef00);
      t0 = $time;
      pm.offer(16'hbe05);
      `CHK("refused gap", 64'd20, $time - t0)
      pm.idle();
      `CHK("after refusal", dod_pkg::op_product_minus_from_acc, ok)
      pm.offer(16'hef00);
      pm.idle();
      rst_b = 1'b0;
      @(negedge clk);
      `CHK("mid reset", {1'b1, 1'b0, dod_pkg::op_none}, {ir, ov, ok})
      rst_b = 1'b1;
      run1(16'hbe32, 0);
      `CHK("after mid reset", dod_pkg::op_pop_acc, ok)
      print_verdict();
   end
endmodule
